/* rtl/psro_pg_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module psro_pg_filter
  import psro_pkg::*;
#(
  parameter int unsigned FILT_CYC = PG_FILT_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic power_good_warning_i,
  output logic      pg_sync_o,
  output logic      pg_fail_o
);

  localparam int unsigned CW = $clog2(FILT_CYC + 1);

  if (FILT_CYC < 1) begin : g_chk
    $error("psro_pg_filter: FILT_CYC must be at least 1");
  end

  logic          meta_ff;
  logic          sync_ff;
  logic [CW-1:0] low_cnt_ff;
  logic          fail_ff;

  // ----------------------------------------------------------------
  // synchroniser and glitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= power_good_warning_i; // RULE_15
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt_ff <= '0;
      fail_ff    <= 1'b0;
    end else if (sync_ff) begin
      low_cnt_ff <= '0; // RULE_06
      fail_ff    <= 1'b0;
    end else if (low_cnt_ff == CW'(FILT_CYC - 1)) begin
      fail_ff    <= 1'b1; // RULE_15
    end else begin
      low_cnt_ff <= low_cnt_ff + CW'(1);
    end
  end

  assign pg_sync_o = sync_ff;
  assign pg_fail_o = fail_ff;

  AST_FILT_LEN: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(fail_ff) |-> $past(low_cnt_ff) == CW'(FILT_CYC - 1)
      && !$past(sync_ff)) // RULE_06
    else $error("power good fail flagged before filter time");

endmodule // psro_pg_filter
`default_nettype wire

/* rtl/psro_pkg.sv */
package psro_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned PG_FILT_NS     = 1000;
  localparam int unsigned PG_FILT_CYC    = (PG_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PG_DLY_NS      = 5000;
  localparam int unsigned PG_DLY_CYC     = (PG_DLY_NS * CLK_MHZ) / 1000;
  localparam int unsigned MIN_PULSE_US   = 2000;
  localparam int unsigned MIN_PULSE_CYC  = MIN_PULSE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_STATUS   = 5'h04;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] OFS_IRQ_EN   = 5'h0c;
  localparam logic [4:0] OFS_IRQ_CLR  = 5'h10;

  localparam int unsigned CTRL_GEN_REL   = 0;
  localparam int unsigned CTRL_MTR_REL   = 1;
  localparam int unsigned CTRL_GEN_FORCE = 2;
  localparam int unsigned CTRL_MTR_FORCE = 3;
  localparam int unsigned CTRL_LAMP_DIS  = 4;
  localparam logic [4:0]  CTRL_RST       = 5'h00;

  localparam int unsigned IRQ_PG_FAIL  = 0;
  localparam int unsigned IRQ_PARKED   = 1;
  localparam int unsigned IRQ_POS_LOSS = 2;
  localparam int unsigned IRQ_INT_RST  = 3;
  localparam int unsigned IRQ_W        = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_RUN  = 2'b01,
    ST_PARK = 2'b10,
    ST_HOLD = 2'b11
  } psro_state_t;

endpackage

/* rtl/psro_rst_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module psro_rst_stretch
  import psro_pkg::*;
#(
  parameter int unsigned MIN_CYC = MIN_PULSE_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic pos_i,
  input  wire logic trig_i,
  input  wire logic force_i,
  input  wire logic release_i,
  output logic      out_n_o,
  output logic      held_o
);

  localparam int unsigned CW = $clog2(MIN_CYC + 1);

  if (MIN_CYC < 2) begin : g_chk
    $error("psro_rst_stretch: MIN_CYC must be at least 2");
  end

  logic          held_ff;
  logic [CW-1:0] cnt_ff;
  logic          out_n_ff;
  logic [CW-1:0] low_len_ff;
  logic          req;

  assign req = !pos_i || trig_i || force_i || held_ff;

  // ----------------------------------------------------------------
  // hold after power-on until released, then stretch
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      held_ff <= 1'b1;
    end else if (!pos_i) begin
      held_ff <= 1'b1; // RULE_10
    end else if (release_i) begin
      held_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= CW'(MIN_CYC);
    end else if (req) begin
      cnt_ff <= CW'(MIN_CYC); // RULE_12
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_n_ff <= 1'b0;
    end else begin
      out_n_ff <= !(req || cnt_ff > CW'(1)); // RULE_12 RULE_13
    end
  end

  assign out_n_o = out_n_ff & pos_i; // RULE_08 RULE_09
  assign held_o  = held_ff;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_len_ff <= '0;
    end else if (out_n_ff) begin
      low_len_ff <= '0;
    end else if (low_len_ff != CW'(MIN_CYC)) begin
      low_len_ff <= low_len_ff + CW'(1);
    end
  end

  AST_MIN_PULSE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(out_n_ff) |-> low_len_ff == CW'(MIN_CYC)) // RULE_12
    else $error("reset output released before minimum width");

  AST_SW_FORCE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    force_i |=> !out_n_o) // RULE_13
    else $error("software force did not assert reset");

  AST_HELD: assert property (@(posedge core_clk_i) disable iff (rst_i)
    held_ff && !release_i |=> !out_n_o [*2]) // RULE_10
    else $error("reset output left before software release");

endmodule // psro_rst_stretch
`default_nettype wire

/* rtl/psro_top.sv */
// What this block does
// RULE_01 - The monitor holds power-on sense low until all supplies reach 90% of minimum.
// RULE_02 - At power-down the monitor drops power-on sense only after power-good fell.
// RULE_03 - The controller leaves reset only while power-good is high.
// RULE_04 - The supervisor drops power-good before any supply collapses.
// RULE_05 - A power-good low lasting the filter time parks the mirrors, then resets.
// RULE_06 - Power-good low pulses shorter than the filter time start nothing.
// RULE_07 - While power-good stays low the controller is held in reset.
// RULE_08 - Both reset outputs are active low.
// RULE_09 - Both outputs drop at once, unclocked, while power-on sense is low.
// RULE_10 - After power-on sense rises each output stays low until software releases it.
// RULE_11 - Outputs also assert about 5 us after a power-good fall or on internal reset.
// RULE_12 - Every assertion of either output lasts at least 2 ms.
// RULE_13 - Software can drive each output on its own through a control register.
// RULE_14 - A software disable keeps lamp strike resets off the motor output.
// RULE_15 - Power-good is synchronised and all times are parameterised counters.
// RULE_16 - The full reset follows only a park acknowledge from mirror control.
`timescale 1ns/1ps
`default_nettype none
module psro_top
  import psro_pkg::*;
#(
  parameter int unsigned FILT_CYC = PG_FILT_CYC,
  parameter int unsigned DLY_CYC  = PG_DLY_CYC,
  parameter int unsigned MIN_CYC  = MIN_PULSE_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        power_on_sense_i,
  input  wire logic        power_good_warning_i,
  input  wire logic        park_ack_i,
  input  wire logic        int_reset_i,
  input  wire logic        lamp_strike_i,
  output logic             general_reset_out_n_o,
  output logic             motor_reset_out_n_o,
  output logic             controller_reset_o,
  output logic             park_req_o,
  output logic             full_reset_o,
  output logic             irq_o,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int unsigned DW = $clog2(DLY_CYC + 1);

  if (DLY_CYC < 1) begin : g_chk
    $error("psro_top: DLY_CYC must be at least 1");
  end

  psro_state_t        state_ff;
  logic               pg_sync;
  logic               pg_fail;
  logic               pg_fail_q_ff;
  logic               pos_q_ff;
  logic [DW-1:0]      dly_cnt_ff;
  logic               dly_fire;
  logic               full_reset_ff;
  logic               gen_trig;
  logic               mtr_trig;
  logic [4:0]         ctrl_ff;
  logic               gen_rel_ff;
  logic               mtr_rel_ff;
  logic [IRQ_W-1:0]   irq_stat_ff;
  logic [IRQ_W-1:0]   irq_en_ff;
  logic [IRQ_W-1:0]   irq_evt;
  logic [IRQ_W-1:0]   irq_clr;
  logic               gen_held;
  logic               mtr_held;
  logic               wr_go;
  logic               rd_go;
  logic [31:0]        nxt_rdata;
  logic [1:0]         nxt_rresp;

  // ----------------------------------------------------------------
  // power-good conditioning
  // ----------------------------------------------------------------
  psro_pg_filter #(
    .FILT_CYC (FILT_CYC)
  ) u_filter (
    .core_clk_i           (core_clk_i),
    .rst_i                (rst_i),
    .power_good_warning_i (power_good_warning_i),
    .pg_sync_o            (pg_sync),
    .pg_fail_o            (pg_fail)
  );

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pg_fail_q_ff <= 1'b0;
      pos_q_ff     <= 1'b0;
    end else begin
      pg_fail_q_ff <= pg_fail;
      pos_q_ff     <= power_on_sense_i;
    end
  end

  // ----------------------------------------------------------------
  // park and reset sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_INIT;
    end else if (!power_on_sense_i) begin
      state_ff <= ST_INIT;
    end else begin
      unique case (state_ff)
        ST_INIT: begin
          if (pg_sync) begin
            state_ff <= ST_RUN; // RULE_03
          end
        end
        ST_RUN: begin
          if (pg_fail) begin
            state_ff <= ST_PARK; // RULE_05 RULE_06
          end
        end
        ST_PARK: begin
          if (park_ack_i) begin
            state_ff <= ST_HOLD; // RULE_16
          end
        end
        ST_HOLD: begin
          if (!pg_fail && pg_sync) begin
            state_ff <= ST_RUN; // RULE_07
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      full_reset_ff <= 1'b0;
    end else begin
      full_reset_ff <= (state_ff == ST_PARK) && park_ack_i; // RULE_16
    end
  end

  assign controller_reset_o = (state_ff != ST_RUN); // RULE_03 RULE_07
  assign park_req_o         = (state_ff == ST_PARK); // RULE_05
  assign full_reset_o       = full_reset_ff;

  // ----------------------------------------------------------------
  // delayed output assertion after power-good loss
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_cnt_ff <= '0;
    end else if (pg_fail && !pg_fail_q_ff) begin
      dly_cnt_ff <= DW'(DLY_CYC); // RULE_11
    end else if (dly_cnt_ff != '0) begin
      dly_cnt_ff <= dly_cnt_ff - DW'(1);
    end
  end

  assign dly_fire = (dly_cnt_ff == DW'(1));

  assign gen_trig = dly_fire || full_reset_ff || int_reset_i; // RULE_11
  assign mtr_trig = gen_trig ||
                    (lamp_strike_i && !ctrl_ff[CTRL_LAMP_DIS]); // RULE_14

  // ----------------------------------------------------------------
  // reset outputs
  // ----------------------------------------------------------------
  psro_rst_stretch #(
    .MIN_CYC (MIN_CYC)
  ) u_gen (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pos_i      (power_on_sense_i),
    .trig_i     (gen_trig),
    .force_i    (ctrl_ff[CTRL_GEN_FORCE]),
    .release_i  (gen_rel_ff),
    .out_n_o    (general_reset_out_n_o),
    .held_o     (gen_held)
  );

  psro_rst_stretch #(
    .MIN_CYC (MIN_CYC)
  ) u_mtr (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pos_i      (power_on_sense_i),
    .trig_i     (mtr_trig),
    .force_i    (ctrl_ff[CTRL_MTR_FORCE]),
    .release_i  (mtr_rel_ff),
    .out_n_o    (motor_reset_out_n_o),
    .held_o     (mtr_held)
  );

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_evt = {int_reset_i,
                    pos_q_ff && !power_on_sense_i,
                    full_reset_ff,
                    pg_fail && !pg_fail_q_ff};

  assign irq_clr = (wr_go && s_axi_awaddr == OFS_IRQ_CLR && s_axi_wstrb[0])
                 ? s_axi_wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_en_ff);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff    <= CTRL_RST;
      irq_en_ff  <= '0;
      gen_rel_ff <= 1'b0;
      mtr_rel_ff <= 1'b0;
    end else begin
      gen_rel_ff <= 1'b0;
      mtr_rel_ff <= 1'b0;
      if (wr_go && s_axi_wstrb[0]) begin
        if (s_axi_awaddr == OFS_CTRL) begin
          ctrl_ff    <= s_axi_wdata[4:0]; // RULE_13 RULE_14
          gen_rel_ff <= s_axi_wdata[CTRL_GEN_REL]; // RULE_10
          mtr_rel_ff <= s_axi_wdata[CTRL_MTR_REL];
        end else if (s_axi_awaddr == OFS_IRQ_EN) begin
          irq_en_ff <= s_axi_wdata[IRQ_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr == OFS_CTRL ||
                       s_axi_awaddr == OFS_IRQ_EN ||
                       s_axi_awaddr == OFS_IRQ_CLR) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;

  always_comb begin
    nxt_rdata = '0;
    nxt_rresp = RESP_OKAY;
    unique case (s_axi_araddr)
      OFS_CTRL: begin
        nxt_rdata[4:0] = ctrl_ff & 5'h1c;
      end
      OFS_STATUS: begin
        nxt_rdata[8:0] = {mtr_held, gen_held, state_ff,
                          motor_reset_out_n_o, general_reset_out_n_o,
                          controller_reset_o, power_on_sense_i, pg_sync};
      end
      OFS_IRQ_STAT: begin
        nxt_rdata[IRQ_W-1:0] = irq_stat_ff;
      end
      OFS_IRQ_EN: begin
        nxt_rdata[IRQ_W-1:0] = irq_en_ff;
      end
      OFS_IRQ_CLR: begin
        nxt_rdata = '0;
      end
      default: begin
        nxt_rresp = RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= nxt_rdata;
      s_axi_rresp  <= nxt_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_park_req;
    park_req_o [*1];
  endsequence

  sequence s_acked;
    park_ack_i && park_req_o ##1 full_reset_o;
  endsequence

  AST_POS_LOW: assert property ( // RULE_09
    !power_on_sense_i |=> !general_reset_out_n_o && !motor_reset_out_n_o)
    else $error("reset outputs high while power-on sense low");

  AST_PG_DELAY: assert property ( // RULE_11
    $rose(pg_fail) && power_on_sense_i |-> ##[1:210] !general_reset_out_n_o)
    else $error("general reset not asserted after power-good loss");

  AST_CTRL_HOLD: assert property ( // RULE_07
    pg_fail && !pg_sync |=> controller_reset_o)
    else $error("controller left reset while power-good low");

  AST_LEAVE_PG: assert property ( // RULE_03
    $fell(controller_reset_o) |-> $past(pg_sync))
    else $error("controller left reset without power-good");

  AST_PARK_FIRST: assert property ( // RULE_05
    state_ff == ST_RUN && pg_fail && power_on_sense_i |=> s_park_req)
    else $error("park not requested on power-good loss");

  AST_FULL_AFTER_ACK: assert property ( // RULE_16
    $rose(full_reset_o) |-> $past(park_ack_i) && $past(park_req_o))
    else $error("full reset without park acknowledge");

  AST_ACK_PULSE: assert property ( // RULE_16
    park_ack_i && park_req_o && power_on_sense_i |-> s_acked)
    else $error("park acknowledge did not give full reset");

  AST_NO_GLITCH_PARK: assert property ( // RULE_06
    $rose(park_req_o) |-> $past(pg_fail))
    else $error("park started by a short power-good glitch");

  AST_LAMP_MTR: assert property ( // RULE_14
    lamp_strike_i && !ctrl_ff[CTRL_LAMP_DIS] |-> ##1 !motor_reset_out_n_o)
    else $error("lamp strike did not reset motor");

endmodule // psro_top
`default_nettype wire

/* test/power_sense_reset_outputs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module power_sense_reset_outputs_bench;
  import psro_pkg::*;
  localparam int unsigned T_MIN = 20;
  logic core_clk, rst, supply_ok, glitch, pos, pg, park_ack, int_rst, lamp;
  logic gen_n, mtr_n, ctrl_rst, park_req, full_rst, irq;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic bready, rready;
  int err_total = 0;
  int checks = 0;
  int fr_cnt = 0;

  psro_monitor #(.GAP(3)) mon_u (.core_clk_i(core_clk), .supply_ok_i(supply_ok),
    .glitch_i(glitch), .power_on_sense_o(pos), .power_good_warning_o(pg));

  psro_top #(.FILT_CYC(4), .DLY_CYC(8), .MIN_CYC(T_MIN)) dut_u (
    .core_clk_i(core_clk), .rst_i(rst), .power_on_sense_i(pos),
    .power_good_warning_i(pg), .park_ack_i(park_ack), .int_reset_i(int_rst),
    .lamp_strike_i(lamp), .general_reset_out_n_o(gen_n),
    .motor_reset_out_n_o(mtr_n), .controller_reset_o(ctrl_rst),
    .park_req_o(park_req), .full_reset_o(full_rst), .irq_o(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (full_rst === 1'b1) fr_cnt <= fr_cnt + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // requests change right after a rising edge and hold until taken
  task automatic axw(input logic [4:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge core_clk); while ((awready && wready) !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axr(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic pulse_in(input int which);
    if (which == 0) int_rst <= 1'b1; else lamp <= 1'b1;
    @(posedge core_clk);
    int_rst <= 1'b0;
    lamp <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge core_clk);
    chk(32'h0, 32'h1);
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; supply_ok = 1'b0; glitch = 1'b0; park_ack = 1'b0;
    int_rst = 1'b0; lamp = 1'b0; awaddr = 5'h00; araddr = 5'h00;
    wdata = 32'h0; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    bready = 1'b0; rready = 1'b0;
    tick(3);
    rst <= 1'b0;
    supply_ok <= 1'b1;
    tick(2);
    chk(ctrl_rst, 1'b1);
    tick(40);
    chk(ctrl_rst, 1'b0);
    chk({gen_n, mtr_n}, 2'b00);
    axr(OFS_CTRL); chk(d, 32'h0); chk(r, RESP_OKAY);
    axw(OFS_CTRL, 32'h03);
    tick(T_MIN - 4); chk({gen_n, mtr_n}, 2'b00);
    tick(10); chk({gen_n, mtr_n}, 2'b11);
    axr(OFS_STATUS); chk(d, 32'h3b);
    for (int i = 0; i < 2; i++) begin
      axw(OFS_CTRL, 32'h04 << i);
      tick(2); chk({gen_n, mtr_n}, (i == 0) ? 2'b01 : 2'b10);
      axr(OFS_CTRL); chk(d, 32'h04 << i);
      axw(OFS_CTRL, 32'h00);
      tick(T_MIN - 4); chk({gen_n, mtr_n}, (i == 0) ? 2'b01 : 2'b10);
      tick(10); chk({gen_n, mtr_n}, 2'b11);
    end
    pulse_in(1);
    tick(2); chk({gen_n, mtr_n}, 2'b10);
    tick(T_MIN + 6); chk({gen_n, mtr_n}, 2'b11);
    axw(OFS_CTRL, 32'h10);
    pulse_in(1);
    tick(2); chk({gen_n, mtr_n}, 2'b11);
    axw(OFS_IRQ_CLR, 32'h0f);
    pulse_in(0);
    tick(2); chk({gen_n, mtr_n}, 2'b00);
    tick(T_MIN - 4); chk({gen_n, mtr_n}, 2'b00);
    tick(8); chk({gen_n, mtr_n}, 2'b11);
    axr(OFS_IRQ_STAT); chk(d, 32'h08);
    chk(irq, 1'b0);
    axw(OFS_IRQ_EN, 32'h08);
    tick(1); chk(irq, 1'b1);
    axr(OFS_IRQ_EN); chk(d, 32'h08);
    axw(OFS_IRQ_CLR, 32'h08);
    tick(1); chk(irq, 1'b0);
    axr(5'h14); chk(r, RESP_SLVERR);
    axw(5'h18, 32'h1f); chk(r, RESP_SLVERR);
    // short warning dip must be ignored
    glitch <= 1'b1;
    tick(2);
    glitch <= 1'b0;
    tick(20);
    chk({park_req, ctrl_rst, gen_n, mtr_n}, 4'h3);
    // long warning: park first, full reset only after ack
    glitch <= 1'b1;
    for (int n = 0; n < 20 && park_req !== 1'b1; n++) @(posedge core_clk);
    chk(park_req, 1'b1);
    chk(ctrl_rst, 1'b1);
    tick(12); chk({gen_n, mtr_n}, 2'b00);
    chk(fr_cnt, 32'h0);
    park_ack <= 1'b1;
    for (int n = 0; n < 20 && park_req === 1'b1; n++) @(posedge core_clk);
    @(posedge core_clk);
    park_ack <= 1'b0;
    tick(3); chk(fr_cnt, 32'h1);
    tick(10); chk(ctrl_rst, 1'b1);
    glitch <= 1'b0;
    tick(12); chk(ctrl_rst, 1'b0);
    axw(OFS_CTRL, 32'h13);
    tick(T_MIN + 10); chk({gen_n, mtr_n}, 2'b11);
    // power down: sense loss drops both outputs without a clock edge
    supply_ok <= 1'b0;
    @(negedge pos);
    #1;
    chk({gen_n, mtr_n}, 2'b00);
    tick(T_MIN + 10); chk({gen_n, mtr_n}, 2'b00);
    supply_ok <= 1'b1;
    tick(40); chk({gen_n, mtr_n}, 2'b00);
    axr(OFS_IRQ_STAT); chk(d, 32'h07);
    complete_run();
  end
endmodule // power_sense_reset_outputs_bench
`default_nettype wire

/* test/psro_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module psro_monitor #(
  parameter int unsigned GAP = 3
) (
  input  wire logic core_clk_i,
  input  wire logic supply_ok_i,
  input  wire logic glitch_i,
  output logic      power_on_sense_o,
  output logic      power_good_warning_o
);
  // ----------------------------------------------------------------
  // supply sequencing
  // ----------------------------------------------------------------
  logic        pos_ff  = 1'b0;
  int unsigned dn_ff   = 0;
  int unsigned up_ff   = 0;

  always @(posedge core_clk_i) begin
    if (supply_ok_i) begin
      dn_ff  <= 0;
      pos_ff <= 1'b1;
    end else begin
      dn_ff <= dn_ff + 1;
      if (dn_ff >= GAP) begin
        pos_ff <= 1'b0;
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (!supply_ok_i || !pos_ff) begin
      up_ff <= 0;
    end else if (up_ff < GAP) begin
      up_ff <= up_ff + 1;
    end
  end

  assign power_on_sense_o = pos_ff;
  // warning drops with the supply request, before sense falls
  assign power_good_warning_o = supply_ok_i && (up_ff >= GAP)
                                && !glitch_i;
endmodule // psro_monitor
`default_nettype wire
